// ### pkg/rtu_defines.vh
// Purpose: Constants for the return instruction unit
// Assumes: 14-bit instruction words, 8-bit accumulator
// Notes:   Definitions only
`ifndef RTU_DEFINES_VH
`define RTU_DEFINES_VH
`define RTU_WORD_W        14
`define RTU_OP_IRQ_RET    14'h0009
`define RTU_OP_SUB_RET    14'h0008
`define RTU_LIT_MASK      14'h3C00
`define RTU_LIT_MATCH     14'h3400
`define RTU_LIT_LSB       0
`define RTU_LIT_MSB       7
`define RTU_IRQ_EN_BIT    7
`define RTU_ICR_RST       8'h00
`define RTU_W_RST         8'h00
`define RTU_PC_RST        13'h0000
`define RTU_KIND_NONE     2'h0
`define RTU_KIND_SUB      2'h1
`define RTU_KIND_IRQ      2'h2
`define RTU_KIND_LIT      2'h3
`endif

// ### core/rtu_decode.v
// Purpose: Classify an instruction word as one of the return kinds
// Assumes: Word is stable while presented
// Notes:   Pure combinational decode
`timescale 1ns/100ps
`include "rtu_defines.vh"
module rtu_decode
(
	// Instruction word
	input  wire [`RTU_WORD_W-1:0] word_in,
	// Decoded kind and literal
	output reg  [1:0]             kind_out,
	output wire [7:0]             literal_out
);
	// Literal is the low byte for every kind; only used on literal return
	assign literal_out = word_in[`RTU_LIT_MSB:`RTU_LIT_LSB];

	// Exact match for fixed words, masked match for literal return
	always @*
	begin
		if (word_in == `RTU_OP_IRQ_RET)
			kind_out = `RTU_KIND_IRQ;
		else if (word_in == `RTU_OP_SUB_RET)
			kind_out = `RTU_KIND_SUB;
		else if ((word_in & `RTU_LIT_MASK) == `RTU_LIT_MATCH)
			kind_out = `RTU_KIND_LIT;
		else
			kind_out = `RTU_KIND_NONE;
	end
endmodule // rtu_decode

// ### core/rtu_return_unit.v
// Purpose: Execute return-type instructions: pop stack into PC, load W, set interrupt enable
// Assumes: Core presents one word per instruction cycle with a valid strobe
// Notes:   Each return takes two cycles; the prefetched word is flushed
//          Outputs are next-value logic plus one register stage
//          Held values (PC, W, control) keep their last load between returns
//          Stack depth and overflow are the stack's own business
`timescale 1ns/100ps
`include "rtu_defines.vh"
// Functional notes
// - Interrupt return word pops stack and loads popped top into PC.
// - Interrupt return sets global interrupt enable, bit 7 of control register.
// - Interrupt return is one word, two instruction cycles.
// - Subroutine return word pops stack and loads popped top into PC.
// - Subroutine return is two cycles, changes no enable or status flag.
// - Word 11 01xx is literal return; loads W with low byte literal.
// - Literal return also loads PC from stack top, two cycles.
module rtu_return_unit
#(
	parameter PC_W = 13
)
(
	// Clock and reset
	input  wire                   sys_clk_in,
	input  wire                   resetn_in,
	// Instruction stream
	input  wire [`RTU_WORD_W-1:0] instr_in,
	input  wire                   instr_valid_in,
	// Stack interface
	input  wire [PC_W-1:0]        stack_top_entry_in,
	output reg                    stack_pop_out,
	// Program counter load
	output reg  [PC_W-1:0]        pc_out,
	output reg                    pc_load_out,
	// Accumulator
	output reg  [7:0]             w_out,
	output reg                    w_load_out,
	// Interrupt control register
	input  wire [7:0]             irq_control_reg_in,
	output reg  [7:0]             irq_control_reg_out,
	output reg                    irq_control_wr_out,
	// Pipeline control
	output reg                    flush_out,
	output reg                    busy_out,
	output reg                    done_out
);
	// Sequencer states: one execute cycle, then one flush cycle
	localparam ST_IDLE  = 1'b0;
	localparam ST_FLUSH = 1'b1;

	// Control register width, handled bit by bit in the merge below
	localparam ICR_W    = 8;

	// Sequencer and the kind of return in flight
	reg              state_r;
	reg              state_nxt;
	reg [1:0]        kind_r;
	reg [1:0]        kind_nxt;

	// Next values of the registered outputs
	reg              stack_pop_nxt;
	reg [PC_W-1:0]   pc_nxt;
	reg              pc_load_nxt;
	reg [7:0]        w_nxt;
	reg              w_load_nxt;
	reg [ICR_W-1:0]  icr_nxt;
	reg              icr_wr_nxt;
	reg              flush_nxt;
	reg              busy_nxt;
	reg              done_nxt;

	// Decode results and qualifiers
	wire [1:0]       kind_dec;
	wire [7:0]       lit_dec;
	wire             is_irq_ret;
	wire             is_sub_ret;
	wire             is_lit_ret;
	wire             is_return;
	wire             in_flush;
	wire             accept;
	wire [ICR_W-1:0] icr_merged;

	// Word decode in its own leaf
	rtu_decode u_dec
	(
		.word_in     (instr_in),
		.kind_out    (kind_dec),
		.literal_out (lit_dec)
	);

	// Kind qualifiers, named once so the next-value logic reads plainly
	assign is_irq_ret = (kind_dec == `RTU_KIND_IRQ);
	assign is_sub_ret = (kind_dec == `RTU_KIND_SUB);
	assign is_lit_ret = (kind_dec == `RTU_KIND_LIT);
	assign is_return  = is_irq_ret || is_sub_ret || is_lit_ret;
	assign in_flush   = (state_r == ST_FLUSH);

	// Words arriving during the flush cycle are the stale prefetch
	// Non-return words fall through untouched; other units own them
	assign accept = instr_valid_in && !in_flush && is_return;

	// Control register merge: enable bit forced high, the rest pass through
	// Done per bit so the enable position stays one named constant
	genvar gi;
	generate
		for (gi = 0; gi < ICR_W; gi = gi + 1)
		begin : g_icr_bit
			if (gi == `RTU_IRQ_EN_BIT)
			begin : g_enable
				// Enable bit set on every interrupt return
				assign icr_merged[gi] = 1'b1;
			end
			else
			begin : g_keep
				// Read-modify-write keeps the other control bits intact
				assign icr_merged[gi] = irq_control_reg_in[gi];
			end
		end
	endgenerate

	// Two-cycle sequencer: execute, then flush cycle
	always @*
	begin
		case (state_r)
			ST_IDLE:  state_nxt = accept ? ST_FLUSH : ST_IDLE;
			ST_FLUSH: state_nxt = ST_IDLE;
			// Default arm recovers from an upset state bit
			default:  state_nxt = ST_IDLE;
		endcase
	end

	// Kind held through the flush cycle so done closes the right return
	// Cleared after the flush so a stale kind cannot close a later cycle
	always @*
	begin
		kind_nxt = kind_r;
		if (accept)
			kind_nxt = kind_dec;
		else if (in_flush)
			kind_nxt = `RTU_KIND_NONE;
	end

	// Execute-cycle strobes, common to every return kind; done is set from the flush cycle instead
	// Busy covers only the flush cycle, so the prefetched word is refused
	always @*
	begin
		stack_pop_nxt = accept;
		pc_load_nxt   = accept;
		flush_nxt     = accept;
		busy_nxt      = accept;
		done_nxt      = in_flush && (kind_r != `RTU_KIND_NONE);
	end

	// Return address sampled from the stack top at the accepting edge
	// Held between returns; the core should take it on the load strobe only
	always @*
	begin
		pc_nxt = pc_out;
		if (accept)
			pc_nxt = stack_top_entry_in;
	end

	// Accumulator load, literal return only
	// Literal is the decoded low byte; bits 9:8 of the word are ignored
	always @*
	begin
		w_nxt      = w_out;
		w_load_nxt = 1'b0;
		if (accept && is_lit_ret)
		begin
			w_nxt      = lit_dec;
			w_load_nxt = 1'b1;
		end
	end

	// Control register write, interrupt return only
	// Subroutine and literal returns leave every flag alone
	always @*
	begin
		icr_nxt    = irq_control_reg_out;
		icr_wr_nxt = 1'b0;
		if (accept && is_irq_ret)
		begin
			icr_nxt    = icr_merged;
			icr_wr_nxt = 1'b1;
		end
	end

	// Single register stage; every output comes straight from a flip-flop
	always @(posedge sys_clk_in)
	begin
		if (!resetn_in)
		begin
			// Reset: strobes low, held values back to their reset constants
			state_r             <= ST_IDLE;
			kind_r              <= `RTU_KIND_NONE;
			stack_pop_out       <= 1'b0;
			pc_out              <= `RTU_PC_RST;
			pc_load_out         <= 1'b0;
			w_out               <= `RTU_W_RST;
			w_load_out          <= 1'b0;
			irq_control_reg_out <= `RTU_ICR_RST;
			irq_control_wr_out  <= 1'b0;
			flush_out           <= 1'b0;
			busy_out            <= 1'b0;
			done_out            <= 1'b0;
		end
		else
		begin
			// Strobes self-clear because their next values default low
			state_r             <= state_nxt;
			kind_r              <= kind_nxt;
			stack_pop_out       <= stack_pop_nxt;
			pc_out              <= pc_nxt;
			pc_load_out         <= pc_load_nxt;
			w_out               <= w_nxt;
			w_load_out          <= w_load_nxt;
			irq_control_reg_out <= icr_nxt;
			irq_control_wr_out  <= icr_wr_nxt;
			flush_out           <= flush_nxt;
			busy_out            <= busy_nxt;
			done_out            <= done_nxt;
		end
	end
endmodule // rtu_return_unit

// ### tb/rtu_sva.sv
// Purpose: Return unit checker
// Assumes: One core clock
// Notes:   Bound by name
`timescale 1ns/100ps
module rtu_sva #(parameter PC_W = 13) (
	input sys_clk_in, resetn_in, instr_valid_in, busy_out, done_out, stack_pop_out, pc_load_out, flush_out,
	input w_load_out, irq_control_wr_out,
	input [13:0] instr_in,
	input [PC_W-1:0] stack_top_entry_in, pc_out,
	input [7:0] w_out, irq_control_reg_out);
	default clocking @(posedge sys_clk_in); endclocking
	default disable iff (!resetn_in);
	// Return words taken while idle; busy words are stale
	wire ok = instr_valid_in && !busy_out, ri = ok && instr_in == 14'h0009, su = ok && instr_in == 14'h0008;
	wire lt = ok && instr_in[13:10] == 4'hD, tk = ri || su || lt;
	a_pop_load: assert property (tk |=> stack_pop_out && pc_load_out) else $error("pop");
	a_irq_en_set: assert property (ri |=> irq_control_wr_out && irq_control_reg_out[7]) else $error("ie");
	a_two_cyc: assert property (tk |=> ##1 done_out) else $error("len");
	a_sub_keep: assert property (su |=> !irq_control_wr_out && !w_load_out) else $error("sub");
	a_lit_w: assert property (lt |=> w_out == $past(instr_in[7:0])) else $error("w");
	a_new_pc: assert property (tk |=> pc_out == $past(stack_top_entry_in)) else $error("pc");
	a_no_stray: assert property (!tk |=> !flush_out) else $error("stray");
	a_one_nop: assert property (flush_out |-> busy_out ##1 !busy_out) else $error("nop");
	cover property (ri);
	cover property (su);
	cover property (lt);
	cover property (tk ##1 instr_valid_in && busy_out);
endmodule // rtu_sva
bind rtu_return_unit rtu_sva #(.PC_W(PC_W)) u_sva (
	.sys_clk_in(sys_clk_in), .resetn_in(resetn_in), .instr_valid_in(instr_valid_in), .busy_out(busy_out),
	.done_out(done_out), .stack_pop_out(stack_pop_out), .pc_load_out(pc_load_out), .flush_out(flush_out),
	.w_load_out(w_load_out), .irq_control_wr_out(irq_control_wr_out), .instr_in(instr_in),
	.stack_top_entry_in(stack_top_entry_in), .pc_out(pc_out), .w_out(w_out),
	.irq_control_reg_out(irq_control_reg_out));

// ### tb/test_rtu_return_unit.sv
// Purpose: Bench for the return instruction unit
// Assumes: Inputs driven and outputs checked at the falling edge
// Notes:   Corner words after each reset, then seeded words; one reset mid-run
`timescale 1ns/100ps
module test_rtu_return_unit;
	localparam int RUN_CYC = 3000;
	localparam int RST_AT  = 1500;
	logic        sys_clk_in = 0, resetn_in = 0, instr_valid_in = 0, b = 0, a;
	logic        stack_pop_out, pc_load_out, w_load_out, irq_control_wr_out, flush_out, busy_out, done_out;
	logic [13:0] instr_in = '0;
	logic [12:0] stack_top_entry_in = '0, pc_out, pc_e = '0;
	logic [7:0]  irq_control_reg_in = '0, w_out, irq_control_reg_out, w_e = '0, icr_e = '0;
	logic [1:0]  k;
	logic [31:0] s = 32'h3D048CB3;
	int          num_errors = 0, comparisons = 0, cyc = 0, ci;
	rtu_return_unit u_rtu_return_unit
	(
		.sys_clk_in          (sys_clk_in),
		.resetn_in           (resetn_in),
		.instr_in            (instr_in),
		.instr_valid_in      (instr_valid_in),
		.stack_top_entry_in  (stack_top_entry_in),
		.stack_pop_out       (stack_pop_out),
		.pc_out              (pc_out),
		.pc_load_out         (pc_load_out),
		.w_out               (w_out),
		.w_load_out          (w_load_out),
		.irq_control_reg_in  (irq_control_reg_in),
		.irq_control_reg_out (irq_control_reg_out),
		.irq_control_wr_out  (irq_control_wr_out),
		.flush_out           (flush_out),
		.busy_out            (busy_out),
		.done_out            (done_out)
	);
	// Clock
	always #5 sys_clk_in = ~sys_clk_in;
	function logic [31:0] xs(input logic [31:0] x);
		x ^= x << 13;
		x ^= x >> 17;
		return x ^ (x << 5);
	endfunction
	// Return kind of a word: 0 none, 1 subroutine, 2 interrupt, 3 literal
	function logic [1:0] kind_of(input logic [13:0] w);
		if (w == 14'h0009) return 2'h2;
		if (w == 14'h0008) return 2'h1;
		return (w[13:10] == 4'hD) ? 2'h3 : 2'h0;
	endfunction
	// Corner words: literal ends, stale prefetch, non-return words, back-to-back
	function logic [13:0] corner(input int i);
		case (i)
			0: return 14'h3400;
			1: return 14'h0009;
			2: return 14'h37FF;
			3: return 14'h0000;
			4: return 14'h3800;
			5: return 14'h000A;
			6: return 14'h0009;
			7: return 14'h0008;
			default: return 14'h0008;
		endcase
	endfunction
	task chk(input [15:0] x, e, input string n);
		comparisons++;
		num_errors += (x !== e);
		if (x !== e) $display("MISMATCH %s exp %h seen %h", n, e, x);
	endtask
	task tally_and_finish;
		$display("checks %0d errors %0d", comparisons, num_errors);
		if (num_errors == 0 && comparisons > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	// Check the edge just past, then drive; b marks a stale prefetch
	always @(negedge sys_clk_in)
	begin
		if (!resetn_in)
		begin
			b = '0;
			pc_e = '0;
			w_e = '0;
			icr_e = '0;
		end
		else
		begin
			k = kind_of(instr_in);
			a = instr_valid_in && !b && k != 2'h0;
			if (a)
				pc_e = stack_top_entry_in;
			if (a && k == 2'h3)
				w_e = instr_in[7:0];
			if (a && k == 2'h2)
				icr_e = irq_control_reg_in | 8'h80;
			chk({stack_pop_out, pc_load_out, flush_out, busy_out}, {4{a}}, "pop");
			chk({w_load_out, irq_control_wr_out, done_out}, {a && k == 2'h3, a && k == 2'h2, b}, "strobe");
			chk(pc_out, pc_e, "pc");
			chk(w_out, w_e, "w");
			chk(irq_control_reg_out, icr_e, "icr");
			b = a;
		end
		s = xs(s);
		cyc++;
		resetn_in = !(cyc < 12 || (cyc >= RST_AT && cyc < RST_AT + 3));
		ci = (cyc >= RST_AT + 3) ? cyc - RST_AT - 3 : cyc - 12;
		instr_valid_in = (ci >= 0 && ci < 9) || s[31] || s[30];
		stack_top_entry_in = s[28:16];
		irq_control_reg_in = s[27:20];
		instr_in = (ci >= 0 && ci < 9) ? corner(ci) : s[3] ? s[13:0] : s[2] ? {4'hD, s[13:4]} :
			s[1] ? {2'h3, s[14:3]} : {13'h0004, s[0]};
	end
	// Run length, then verdict
	initial
	begin
		repeat (RUN_CYC) @(posedge sys_clk_in);
		$display("test done: %0d cycles", RUN_CYC);
		tally_and_finish;
	end
	// Watchdog: twice the planned run
	initial
	begin
		#(2 * RUN_CYC * 10);
		num_errors++;
		tally_and_finish;
	end
endmodule // test_rtu_return_unit
